// *** logic/csi_pkg.sv ***
// constants, types and register map of the card status change interrupt block
package csi_pkg;

    // ------------------------------------------------------------------
    // register indices; byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [7:0] CSI_IDX_FLAGS = 8'h04;
    localparam logic [7:0] CSI_IDX_CFG   = 8'h05;
    localparam logic [7:0] CSI_IDX_MASK  = 8'h06;
    localparam logic [7:0] CSI_IDX_CTRL  = 8'h07;
    localparam logic [7:0] CSI_IDX_PINS  = 8'h08;

    // ------------------------------------------------------------------
    // field positions of the change flags, config low nibble and mask
    // ------------------------------------------------------------------
    localparam int CSI_BIT_FAIL   = 0;
    localparam int CSI_BIT_LOW    = 1;
    localparam int CSI_BIT_READY  = 2;
    localparam int CSI_BIT_DETECT = 3;
    localparam int CSI_NUM_FLAGS  = 4;

    // control register fields
    localparam int CSI_CTRL_IO_CARD = 0;
    localparam int CSI_CTRL_RING_ON = 1;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] CSI_CFG_RST   = 8'h00;
    localparam logic [3:0] CSI_FLAGS_RST = 4'h0;
    localparam logic [3:0] CSI_MASK_RST  = 4'h0;
    localparam logic [1:0] CSI_CTRL_RST  = 2'h0;

    // ------------------------------------------------------------------
    // steering: code n selects system line n; reserved codes select none
    // ------------------------------------------------------------------
    localparam int          CSI_NUM_LINES   = 16;
    localparam logic [15:0] CSI_ROUTE_VALID = 16'hdeb8;

    // axi response codes
    localparam logic [1:0] CSI_RESP_OKAY   = 2'h0;
    localparam logic [1:0] CSI_RESP_SLVERR = 2'h2;

    // configuration register layout
    typedef struct packed {
        logic [3:0] irq_route_select;
        logic       detect_change_irq_on;
        logic       ready_rise_irq_on;
        logic       battery_low_irq_on;
        logic       battery_fail_irq_on;
    } csi_cfg_s;

    // card side pin levels
    typedef struct packed {
        logic [1:0] card_present_n;
        logic       card_ready_busy;
        logic       battery_low;
        logic       battery_fail;
        logic       card_change_ring_n;
    } csi_card_s;

    localparam int CSI_CARD_W = 6;

endpackage

// *** logic/csi_sync.sv ***
// two flip-flop synchroniser, one chain per bit
`timescale 1ns/10ps
module csi_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    // data
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic meta_q;
            logic safe_q;
            // first stage feeds only the second
            always_ff @(posedge clk_in) begin
                if (rst_in) begin
                    meta_q <= 1'b0;
                    safe_q <= 1'b0;
                end else begin
                    meta_q <= async_in[i];
                    safe_q <= meta_q;
                end
            end
            assign sync_out[i] = safe_q;
        end
    endgenerate

endmodule

// *** logic/csi_irq_route.sv ***
// steering of the status change interrupt onto one system line
`timescale 1ns/10ps
module csi_irq_route (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // request
    input  wire logic [3:0]  route_in,
    input  wire logic        active_in,
    // system lines
    output logic      [15:0] lines_out
);

    genvar n;
    generate
        for (n = 0; n < csi_pkg::CSI_NUM_LINES; n++) begin : g_line
            always_ff @(posedge clk_in) begin
                if (rst_in) begin
                    lines_out[n] <= 1'b0;
                end else begin
                    // reserved and zero codes drive nothing
                    lines_out[n] <= active_in && csi_pkg::CSI_ROUTE_VALID[n]
                                    && (route_in == 4'(n));
                end
            end
        end
    endgenerate

endmodule

// *** logic/csi_top.sv ***
// card status change detection, flags, steering and axi4-lite registers
`timescale 1ns/10ps
module csi_top #(
    parameter int AW = 8
) (
    // clock and reset
    input  wire logic          clk_in,
    input  wire logic          rst_in,
    // axi4-lite write address
    input  wire logic [AW-1:0] s_axi_awaddr_in,
    input  wire logic          s_axi_awvalid_in,
    output logic               s_axi_awready_out,
    // axi4-lite write data
    input  wire logic [31:0]   s_axi_wdata_in,
    input  wire logic [3:0]    s_axi_wstrb_in,
    input  wire logic          s_axi_wvalid_in,
    output logic               s_axi_wready_out,
    // axi4-lite write response
    output logic [1:0]         s_axi_bresp_out,
    output logic               s_axi_bvalid_out,
    input  wire logic          s_axi_bready_in,
    // axi4-lite read address
    input  wire logic [AW-1:0] s_axi_araddr_in,
    input  wire logic          s_axi_arvalid_in,
    output logic               s_axi_arready_out,
    // axi4-lite read data
    output logic [31:0]        s_axi_rdata_out,
    output logic [1:0]         s_axi_rresp_out,
    output logic               s_axi_rvalid_out,
    input  wire logic          s_axi_rready_in,
    // card socket pins
    input  wire logic [1:0]    card_present_n_in,
    input  wire logic          card_ready_busy_in,
    input  wire logic          battery_low_in,
    input  wire logic          battery_fail_in,
    input  wire logic          card_change_ring_n_in,
    // interrupts
    output logic [15:0]        irq_lines_out,
    output logic               irq_out
);

    // ------------------------------------------------------------------
    // byte addresses
    // ------------------------------------------------------------------
    localparam logic [AW-1:0] ADDR_FLAGS = AW'({csi_pkg::CSI_IDX_FLAGS, 2'b00});
    localparam logic [AW-1:0] ADDR_CFG   = AW'({csi_pkg::CSI_IDX_CFG, 2'b00});
    localparam logic [AW-1:0] ADDR_MASK  = AW'({csi_pkg::CSI_IDX_MASK, 2'b00});
    localparam logic [AW-1:0] ADDR_CTRL  = AW'({csi_pkg::CSI_IDX_CTRL, 2'b00});
    localparam logic [AW-1:0] ADDR_PINS  = AW'({csi_pkg::CSI_IDX_PINS, 2'b00});

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    csi_pkg::csi_card_s card_raw;
    csi_pkg::csi_card_s card_now;
    csi_pkg::csi_card_s card_prev_q;
    csi_pkg::csi_cfg_s  cfg_q;

    logic [3:0]    flags_q;
    logic [3:0]    flags_d;
    logic [3:0]    flag_set;
    logic [3:0]    flag_clr;
    logic [3:0]    mask_q;
    logic [1:0]    ctrl_q;
    logic          io_card;
    logic          ring_on;
    logic          route_active;

    logic          awready_q;
    logic          wready_q;
    logic          aw_held_q;
    logic          w_held_q;
    logic [AW-1:0] waddr_q;
    logic [31:0]   wdata_q;
    logic          wlane0_q;
    logic          bvalid_q;
    logic [1:0]    bresp_q;
    logic          commit;
    logic          wr_flags;
    logic          wr_cfg;
    logic          wr_mask;
    logic          wr_ctrl;
    logic          wr_known;

    logic          arready_q;
    logic          rvalid_q;
    logic [31:0]   rdata_q;
    logic [1:0]    rresp_q;
    logic [31:0]   rd_word;
    logic          rd_known;
    logic          irq_q;

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    assign card_raw = {card_present_n_in, card_ready_busy_in, battery_low_in,
                       battery_fail_in, card_change_ring_n_in};

    csi_sync #(
        .W (csi_pkg::CSI_CARD_W)
    ) u_sync (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .async_in (card_raw),
        .sync_out (card_now)
    );

    // previous levels for edge detection
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            card_prev_q <= '0;
        end else begin
            card_prev_q <= card_now;
        end
    end

    // ------------------------------------------------------------------
    // change events
    // ------------------------------------------------------------------
    assign io_card = ctrl_q[csi_pkg::CSI_CTRL_IO_CARD];
    assign ring_on = ctrl_q[csi_pkg::CSI_CTRL_RING_ON];

    // a source with its enable off never latches a flag
    always_comb begin
        flag_set = 4'h0;
        flag_set[csi_pkg::CSI_BIT_DETECT] = cfg_q.detect_change_irq_on
            && (card_now.card_present_n != card_prev_q.card_present_n);
        flag_set[csi_pkg::CSI_BIT_READY] = cfg_q.ready_rise_irq_on && !io_card
            && card_now.card_ready_busy && !card_prev_q.card_ready_busy;
        flag_set[csi_pkg::CSI_BIT_LOW] = cfg_q.battery_low_irq_on && !io_card
            && card_now.battery_low && !card_prev_q.battery_low;
        if (io_card) begin
            // ring level keeps re-arming the flag while the card holds it low and ring_on is clear
            flag_set[csi_pkg::CSI_BIT_FAIL] = cfg_q.battery_fail_irq_on && !ring_on
                && !card_now.card_change_ring_n;
        end else begin
            flag_set[csi_pkg::CSI_BIT_FAIL] = cfg_q.battery_fail_irq_on
                && card_now.battery_fail && !card_prev_q.battery_fail;
        end
    end

    // write one to clear
    assign flag_clr = (wr_flags && wlane0_q) ? wdata_q[3:0] : 4'h0;

    always_comb begin
        // set wins over a clear in the same cycle
        flags_d = (flags_q & ~flag_clr) | flag_set;
        if (io_card) begin
            flags_d[csi_pkg::CSI_BIT_READY] = 1'b0;
            flags_d[csi_pkg::CSI_BIT_LOW]   = 1'b0;
        end
        if (!io_card && !card_now.battery_fail) begin
            flags_d[csi_pkg::CSI_BIT_FAIL] = flag_set[csi_pkg::CSI_BIT_FAIL];
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            flags_q <= csi_pkg::CSI_FLAGS_RST;
        end else begin
            flags_q <= flags_d;
        end
    end

    // ------------------------------------------------------------------
    // write channel
    // ------------------------------------------------------------------
    assign commit   = aw_held_q && w_held_q && !bvalid_q;
    assign wr_flags = commit && (waddr_q == ADDR_FLAGS);
    assign wr_cfg   = commit && (waddr_q == ADDR_CFG);
    assign wr_mask  = commit && (waddr_q == ADDR_MASK);
    assign wr_ctrl  = commit && (waddr_q == ADDR_CTRL);
    assign wr_known = wr_flags || wr_cfg || wr_mask || wr_ctrl
                      || (waddr_q == ADDR_PINS);

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            awready_q <= 1'b0;
        end else if (s_axi_awvalid_in && awready_q) begin
            awready_q <= 1'b0;
        end else if (!aw_held_q && !bvalid_q) begin
            awready_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            aw_held_q <= 1'b0;
            waddr_q   <= '0;
        end else if (s_axi_awvalid_in && awready_q) begin
            aw_held_q <= 1'b1;
            waddr_q   <= {s_axi_awaddr_in[AW-1:2], 2'b00};
        end else if (commit) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wready_q <= 1'b0;
        end else if (s_axi_wvalid_in && wready_q) begin
            wready_q <= 1'b0;
        end else if (!w_held_q && !bvalid_q) begin
            wready_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            w_held_q <= 1'b0;
            wdata_q  <= '0;
            wlane0_q <= 1'b0;
        end else if (s_axi_wvalid_in && wready_q) begin
            w_held_q <= 1'b1;
            wdata_q  <= s_axi_wdata_in;
            wlane0_q <= s_axi_wstrb_in[0];
        end else if (commit) begin
            w_held_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            bvalid_q <= 1'b0;
            bresp_q  <= csi_pkg::CSI_RESP_OKAY;
        end else if (commit) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_known ? csi_pkg::CSI_RESP_OKAY : csi_pkg::CSI_RESP_SLVERR;
        end else if (s_axi_bready_in) begin
            bvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------------
    // only byte lane 0 carries register bits
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cfg_q <= csi_pkg::CSI_CFG_RST;
        end else if (wr_cfg && wlane0_q) begin
            cfg_q <= wdata_q[7:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            mask_q <= csi_pkg::CSI_MASK_RST;
        end else if (wr_mask && wlane0_q) begin
            mask_q <= wdata_q[3:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ctrl_q <= csi_pkg::CSI_CTRL_RST;
        end else if (wr_ctrl && wlane0_q) begin
            ctrl_q <= wdata_q[1:0];
        end
    end

    // ------------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------------
    always_comb begin
        rd_word  = 32'h0000_0000;
        rd_known = 1'b1;
        case ({s_axi_araddr_in[AW-1:2], 2'b00})
            ADDR_FLAGS: rd_word[3:0] = flags_q;
            ADDR_CFG:   rd_word[7:0] = cfg_q;
            ADDR_MASK:  rd_word[3:0] = mask_q;
            ADDR_CTRL:  rd_word[1:0] = ctrl_q;
            ADDR_PINS:  rd_word[5:0] = card_now;
            default:    rd_known     = 1'b0;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            arready_q <= 1'b0;
        end else if (s_axi_arvalid_in && arready_q) begin
            arready_q <= 1'b0;
        end else if (!rvalid_q) begin
            arready_q <= 1'b1;
        end
    end

    // reads have no side effect; flags clear by write, io card mode, or battery_fail low on a memory card
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= csi_pkg::CSI_RESP_OKAY;
        end else if (s_axi_arvalid_in && arready_q) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_word;
            rresp_q  <= rd_known ? csi_pkg::CSI_RESP_OKAY : csi_pkg::CSI_RESP_SLVERR;
        end else if (s_axi_rready_in) begin
            rvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // interrupt outputs
    // ------------------------------------------------------------------
    // enables checked again so turning one off withdraws a pending request from the system lines only
    assign route_active = |(flags_q & cfg_q[3:0]);

    csi_irq_route u_route (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .route_in  (cfg_q.irq_route_select),
        .active_in (route_active),
        .lines_out (irq_lines_out)
    );

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(flags_q & mask_q);
        end
    end

    // ------------------------------------------------------------------
    // output drive
    // ------------------------------------------------------------------
    assign s_axi_awready_out = awready_q;
    assign s_axi_wready_out  = wready_q;
    assign s_axi_bvalid_out  = bvalid_q;
    assign s_axi_bresp_out   = bresp_q;
    assign s_axi_arready_out = arready_q;
    assign s_axi_rvalid_out  = rvalid_q;
    assign s_axi_rdata_out   = rdata_q;
    assign s_axi_rresp_out   = rresp_q;
    assign irq_out           = irq_q;

endmodule

// *** dv/csi_card_model.sv ***
// behavioural model of the card socket pins
`timescale 1ns/10ps
module csi_card_model (
    // socket pins
    output csi_pkg::csi_card_s card_out
);
    // ----------------------------------------
    // pin levels
    // ----------------------------------------
    // idle: card present, busy, no battery faults, ring line pulled up
    initial begin
        card_out = 6'h01;
    end

    // called just after a clock edge; pins are async to the block anyway
    task automatic drive(input csi_pkg::csi_card_s v);
        card_out <= v;
    endtask
endmodule

// *** dv/csi_top_asserts.sv ***
// concurrent checks on the ports of the card status change block
`timescale 1ns/10ps
module csi_top_asserts #(
    parameter int AW = 8
) (
    // clock and reset
    input wire logic          clk_in,
    input wire logic          rst_in,
    // register bus
    input wire logic          s_axi_awvalid_in,
    input wire logic          s_axi_awready_out,
    input wire logic          s_axi_wvalid_in,
    input wire logic          s_axi_wready_out,
    input wire logic          s_axi_bvalid_out,
    input wire logic          s_axi_bready_in,
    input wire logic [AW-1:0] s_axi_araddr_in,
    input wire logic          s_axi_arvalid_in,
    input wire logic          s_axi_arready_out,
    input wire logic [31:0]   s_axi_rdata_out,
    input wire logic          s_axi_rvalid_out,
    input wire logic          s_axi_rready_in,
    // interrupts
    input wire logic [15:0]   irq_lines_out,
    input wire logic          irq_out
);
    // ----------------------------------------
    // helpers and properties
    // ----------------------------------------
    logic [AW-1:0] rd_addr_q;

    always_ff @(posedge clk_in) begin
        if (s_axi_arvalid_in && s_axi_arready_out) begin
            rd_addr_q <= s_axi_araddr_in;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence s_wr_taken;
        s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid_in && s_axi_arready_out;
    endsequence

    property p_upper_zero;
        s_axi_rvalid_out && rd_addr_q == AW'(8'h10) |-> s_axi_rdata_out[31:4] == 28'h0;
    endproperty
    property p_reset_quiet;
        disable iff (1'b0) rst_in |=> irq_out == 1'b0 && irq_lines_out == 16'h0;
    endproperty
    property p_lines_legal;
        (irq_lines_out & ~csi_pkg::CSI_ROUTE_VALID) == 16'h0;
    endproperty
    property p_one_line;
        $onehot0(irq_lines_out);
    endproperty
    property p_wr_answer;
        s_wr_taken |=> !s_axi_bvalid_out ##1 s_axi_bvalid_out;
    endproperty
    property p_rd_answer;
        s_rd_taken |=> s_axi_rvalid_out && !s_axi_arready_out;
    endproperty
    property p_aw_drop;
        s_axi_awvalid_in && s_axi_awready_out |=> !s_axi_awready_out;
    endproperty
    property p_b_once;
        s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out;
    endproperty
    property p_r_once;
        s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out;
    endproperty

    a_upper_zero: assert property (p_upper_zero) else $error("flag upper bits set");
    a_reset_quiet: assert property (p_reset_quiet) else $error("interrupt active after reset");
    a_lines_legal: assert property (p_lines_legal) else $error("reserved line driven");
    a_one_line: assert property (p_one_line) else $error("several lines driven");
    a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
    a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
    a_aw_drop: assert property (p_aw_drop) else $error("write address taken twice");
    a_b_once: assert property (p_b_once) else $error("write answer repeated");
    a_r_once: assert property (p_r_once) else $error("read answer repeated");
endmodule

bind csi_top csi_top_asserts #(.AW(AW)) csi_top_asserts_inst (
    .clk_in(clk_in), .rst_in(rst_in), .s_axi_awvalid_in(s_axi_awvalid_in),
    .s_axi_awready_out(s_axi_awready_out), .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
    .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in), .s_axi_araddr_in(s_axi_araddr_in),
    .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out), .s_axi_rdata_out(s_axi_rdata_out),
    .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in), .irq_lines_out(irq_lines_out),
    .irq_out(irq_out));

// *** dv/test_card_status_change_irq.sv ***
// register-level testbench of the card status change block
`timescale 1ns/10ps
module test_card_status_change_irq;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    localparam logic [15:0] LINES_OK = 16'hdeb8;
    logic               clk_in;
    logic               rst_in;
    logic [7:0]         awaddr, araddr;
    logic [31:0]        wdata, rdata;
    logic               awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid, irq;
    logic [1:0]         bresp, rresp;
    logic [15:0]        irq_lines;
    csi_pkg::csi_card_s card;
    int                 err_count, check_count, code;

    csi_card_model csi_card_model_inst (.card_out(card));

    csi_top csi_top_inst (
        .clk_in(clk_in), .rst_in(rst_in), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
        .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(1'b1),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(1'b1),
        .card_present_n_in(card.card_present_n), .card_ready_busy_in(card.card_ready_busy),
        .battery_low_in(card.battery_low), .battery_fail_in(card.battery_fail),
        .card_change_ring_n_in(card.card_change_ring_n), .irq_lines_out(irq_lines), .irq_out(irq));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic hang();
        err_count++;
        $display("unexpected at %0t: no bus answer", $time);
        finish_test();
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    // ready lines are tied high, so every answer is taken at its first edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp = csi_pkg::CSI_RESP_OKAY);
        int n;
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk_in);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 40) hang();
        check({30'h0, bresp}, {30'h0, resp});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] resp);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk_in);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 40) hang();
        check(rdata, exp);
        check({30'h0, rresp}, {30'h0, resp});
    endtask

    // pin order: present_n[1:0], ready, battery low, battery dead, ring_n
    task automatic pins(input logic [5:0] v);
        csi_card_model_inst.drive(csi_pkg::csi_card_s'(v));
        tick(8);
    endtask

    // ----------------------------------------
    // clock, reset and sequence
    // ----------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end

    initial begin
        rst_in = 1'b1;
        awaddr = 8'h0;
        araddr = 8'h0;
        wdata = 32'h0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        arvalid = 1'b0;
        err_count = 0;
        check_count = 0;
        tick(6);
        rst_in <= 1'b0;
        tick(2);
        rd(8'h10, 32'h0, csi_pkg::CSI_RESP_OKAY);
        rd(8'h14, 32'h0, csi_pkg::CSI_RESP_OKAY);
        rd(8'h18, 32'h0, csi_pkg::CSI_RESP_OKAY);
        rd(8'h3c, 32'h0, csi_pkg::CSI_RESP_SLVERR);
        wr(8'h3c, 32'h1, csi_pkg::CSI_RESP_SLVERR);
        wr(8'h14, 32'ha5);
        rd(8'h14, 32'ha5, csi_pkg::CSI_RESP_OKAY);
        wr(8'h14, 32'h30);
        // presence, ready and battery-low changes with enables off leave no trace
        pins(6'h1d);
        rd(8'h10, 32'h0, csi_pkg::CSI_RESP_OKAY);
        check({16'h0, irq_lines}, 32'h0);
        wr(8'h14, 32'h38);
        pins(6'h01);
        rd(8'h10, 32'h8, csi_pkg::CSI_RESP_OKAY);
        check({16'h0, irq_lines}, 32'h8);
        check({31'h0, irq}, 32'h0);
        wr(8'h18, 32'h8);
        tick(2);
        check({31'h0, irq}, 32'h1);
        for (code = 0; code < 16; code++) begin
            wr(8'h14, {24'h0, code[3:0], 4'h8});
            tick(3);
            check({16'h0, irq_lines}, LINES_OK[code] ? (32'h1 << code) : 32'h0);
        end
        wr(8'h14, 32'h30);
        tick(3);
        check({16'h0, irq_lines}, 32'h0);
        rd(8'h10, 32'h8, csi_pkg::CSI_RESP_OKAY);
        wr(8'h10, 32'hf8);
        rd(8'h10, 32'h0, csi_pkg::CSI_RESP_OKAY);
        tick(2);
        check({31'h0, irq}, 32'h0);
        // memory card: ready rise, battery low, battery dead in turn
        wr(8'h14, 32'h3f);
        wr(8'h18, 32'hf);
        pins(6'h09);
        rd(8'h10, 32'h4, csi_pkg::CSI_RESP_OKAY);
        pins(6'h0d);
        rd(8'h10, 32'h6, csi_pkg::CSI_RESP_OKAY);
        pins(6'h0f);
        rd(8'h10, 32'h7, csi_pkg::CSI_RESP_OKAY);
        check({31'h0, irq}, 32'h1);
        pins(6'h0d);
        rd(8'h10, 32'h6, csi_pkg::CSI_RESP_OKAY);
        pins(6'h07);
        wr(8'h10, 32'hf);
        tick(3);
        rd(8'h10, 32'h0, csi_pkg::CSI_RESP_OKAY);
        check({16'h0, irq_lines}, 32'h0);
        // io card: ready and battery low ignored, ring sets bit0
        wr(8'h1c, 32'h1);
        pins(6'h01);
        wr(8'h10, 32'hf);
        pins(6'h0d);
        rd(8'h10, 32'h0, csi_pkg::CSI_RESP_OKAY);
        pins(6'h0c);
        rd(8'h10, 32'h1, csi_pkg::CSI_RESP_OKAY);
        rd(8'h20, 32'hc, csi_pkg::CSI_RESP_OKAY);
        check({31'h0, irq}, 32'h1);
        wr(8'h1c, 32'h3);
        wr(8'h10, 32'h1);
        tick(3);
        rd(8'h10, 32'h0, csi_pkg::CSI_RESP_OKAY);
        // mid-run reset with a flag pending and every register written
        wr(8'h1c, 32'h1);
        tick(3);
        check({31'h0, irq}, 32'h1);
        rst_in <= 1'b1;
        tick(2);
        rst_in <= 1'b0;
        tick(2);
        check({31'h0, irq}, 32'h0);
        check({16'h0, irq_lines}, 32'h0);
        rd(8'h10, 32'h0, csi_pkg::CSI_RESP_OKAY);
        rd(8'h14, 32'h0, csi_pkg::CSI_RESP_OKAY);
        rd(8'h18, 32'h0, csi_pkg::CSI_RESP_OKAY);
        rd(8'h1c, 32'h0, csi_pkg::CSI_RESP_OKAY);
        finish_test();
    end
endmodule
